// *** core/lcdr_pkg.sv ***
package lcdr_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int CH_COUNT = 14;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CH_IDX_W = 4;

	// ------------------------------------------------------------
	// Register map: channel n sits at n * 0x10 plus the offset
	// ------------------------------------------------------------
	localparam logic [3:0] REG_JITTER_CFG_OFS = 4'h1;
	localparam logic [3:0] REG_TEST_LOOP_OFS = 4'h2;
	localparam logic [7:0] JITTER_CFG_RST = 8'h00;
	localparam logic [7:0] TEST_LOOP_RST = 8'h00;
	localparam logic [7:0] READ_IDLE_VAL = 8'h00;

	// Field positions in the jitter configuration register
	localparam int JA_BW_BIT = 1;
	localparam int JA_DEPTH_BIT = 0;

	// Field positions in the test and loopback register
	localparam int PAT_INV_BIT = 7;
	localparam int PAT_SEL_HI = 6;
	localparam int PAT_SEL_LO = 4;
	localparam int TX_ON_BIT = 3;
	localparam int LOOP_HI = 2;
	localparam int LOOP_LO = 0;

	// ------------------------------------------------------------
	// Jitter attenuator settings
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LCDR_BW_10HZ = 2'h0,
		LCDR_BW_1P5HZ = 2'h1,
		LCDR_BW_3HZ = 2'h2
	} lcdr_ja_bw_t;

	localparam logic [6:0] FIFO_DEPTH_SHORT = 7'h20;
	localparam logic [6:0] FIFO_DEPTH_LONG = 7'h40;

	// ------------------------------------------------------------
	// Test pattern and loopback codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LCDR_PAT_NONE = 2'h0,
		LCDR_PAT_QRSS = 2'h1,
		LCDR_PAT_TAOS = 2'h2,
		LCDR_PAT_RSVD = 2'h3
	} lcdr_pat_t;

	typedef enum logic [2:0] {
		LCDR_LOOP_NONE = 3'h0,
		LCDR_LOOP_DUAL = 3'h1,
		LCDR_LOOP_ANALOG = 3'h2,
		LCDR_LOOP_REMOTE = 3'h3,
		LCDR_LOOP_DIGITAL = 3'h4
	} lcdr_loop_t;

endpackage

// *** core/lcdr_addr_dec.sv ***
`timescale 1ns/1ns
module lcdr_addr_dec #(
	parameter int CH_COUNT = lcdr_pkg::CH_COUNT
) (
	input wire logic [lcdr_pkg::ADDR_W-1:0] addr_i,
	output logic [lcdr_pkg::CH_IDX_W-1:0] ch_idx_o,
	output logic sel_jitter_o,
	output logic sel_test_loop_o
);
	import lcdr_pkg::*;

	logic ch_ok;

	// ------------------------------------------------------------
	// Upper nibble picks the channel, lower nibble the register
	// ------------------------------------------------------------
	always_comb begin
		ch_idx_o = addr_i[7:4];
		ch_ok = (32'(addr_i[7:4]) < CH_COUNT);
		sel_jitter_o = ch_ok && (addr_i[3:0] == REG_JITTER_CFG_OFS);
		sel_test_loop_o = ch_ok && (addr_i[3:0] == REG_TEST_LOOP_OFS);
	end

endmodule

// *** core/lcdr_ch_decode.sv ***
`timescale 1ns/1ns
module lcdr_ch_decode (
	input wire logic [lcdr_pkg::DATA_W-1:0] jitter_cfg_i,
	input wire logic [lcdr_pkg::DATA_W-1:0] test_loop_i,
	input wire logic e1_mode_i,
	input wire logic global_tx_enable_i,
	output logic [1:0] ja_bandwidth_o,
	output logic [6:0] ja_fifo_depth_o,
	output logic [5:0] ja_fifo_delay_o,
	output logic [1:0] tx_pattern_o,
	output logic tx_pattern_invert_o,
	output logic tx_power_on_o,
	output logic [2:0] loopback_o
);
	import lcdr_pkg::*;

	logic [2:0] pat_field;
	logic [2:0] loop_field;

	always_comb begin
		pat_field = test_loop_i[PAT_SEL_HI:PAT_SEL_LO];
		loop_field = test_loop_i[LOOP_HI:LOOP_LO];

		// ------------------------------------------------------------
		// Jitter attenuator
		// ------------------------------------------------------------
		if (!e1_mode_i) begin
			ja_bandwidth_o = LCDR_BW_3HZ;
		end else if (jitter_cfg_i[JA_BW_BIT]) begin
			ja_bandwidth_o = LCDR_BW_1P5HZ;
		end else begin
			ja_bandwidth_o = LCDR_BW_10HZ;
		end
		ja_fifo_depth_o = jitter_cfg_i[JA_DEPTH_BIT] ? FIFO_DEPTH_LONG : FIFO_DEPTH_SHORT;
		ja_fifo_delay_o = ja_fifo_depth_o[6:1];

		// ------------------------------------------------------------
		// Test pattern
		// ------------------------------------------------------------
		case (pat_field)
			3'h4: tx_pattern_o = LCDR_PAT_QRSS;
			3'h5: tx_pattern_o = LCDR_PAT_TAOS;
			3'h6, 3'h7: tx_pattern_o = LCDR_PAT_RSVD;
			default: tx_pattern_o = LCDR_PAT_NONE;
		endcase
		// QRSS goes out inverted by default, PRBS straight; a set bit flips both
		if (tx_pattern_o == LCDR_PAT_QRSS) begin
			tx_pattern_invert_o = !test_loop_i[PAT_INV_BIT];
		end else begin
			tx_pattern_invert_o = test_loop_i[PAT_INV_BIT];
		end

		// ------------------------------------------------------------
		// Transmitter power and loopback
		// ------------------------------------------------------------
		tx_power_on_o = global_tx_enable_i && test_loop_i[TX_ON_BIT];

		case (loop_field)
			3'h4: loopback_o = LCDR_LOOP_DUAL;
			3'h5: loopback_o = LCDR_LOOP_ANALOG;
			3'h6: loopback_o = LCDR_LOOP_REMOTE;
			3'h7: loopback_o = LCDR_LOOP_DIGITAL;
			default: loopback_o = LCDR_LOOP_NONE;
		endcase
	end

endmodule

// *** core/lcdr_ctrl_regs.sv ***
`timescale 1ns/1ns
// What this block does
// - In E1 mode bandwidth bit 0 gives 10 Hz and 1 gives 1.5 Hz, in T1 mode it is 3 Hz from the first clock after reset, which loads 10 Hz.
// - One bandwidth setting serves both the receive and the transmit jitter attenuator.
// - Depth bit 0 gives a 32-bit FIFO and 1 gives a 64-bit FIFO.
// - The FIFO delay is half of the selected depth.
// - One depth setting serves both the receive and the transmit FIFO.
// - With the invert bit at 0, PRBS goes out straight and QRSS goes out inverted.
// - Pattern field 0XX is none, 100 QRSS, 101 all ones, 110 and 111 reserved.
// - Transmitters are off after power-up and follow their own on bit while the global pin is high.
// - While the global transmit enable pin is low all fourteen transmitters stay off.
// - Loopback field 0XX is none, 100 dual, 101 analog, 110 remote, 111 digital.
module lcdr_ctrl_regs #(
	parameter int CH_COUNT = lcdr_pkg::CH_COUNT
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [lcdr_pkg::ADDR_W-1:0] addr_i,
	input wire logic [lcdr_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	output logic [lcdr_pkg::DATA_W-1:0] rd_data_o,
	input wire logic [CH_COUNT-1:0] e1_mode_i,
	input wire logic global_tx_enable_i,
	output logic [CH_COUNT-1:0][1:0] ja_bandwidth_o,
	output logic [CH_COUNT-1:0][6:0] ja_fifo_depth_o,
	output logic [CH_COUNT-1:0][5:0] ja_fifo_delay_o,
	output logic [CH_COUNT-1:0][1:0] tx_pattern_o,
	output logic [CH_COUNT-1:0] tx_pattern_invert_o,
	output logic [CH_COUNT-1:0] tx_power_on_o,
	output logic [CH_COUNT-1:0][2:0] loopback_o
);
	import lcdr_pkg::*;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	// Only the two jitter bits of the first register live here
	logic [CH_COUNT-1:0][1:0] jitter_cfg_r;
	logic [CH_COUNT-1:0][1:0] jitter_cfg_nxt;
	logic [CH_COUNT-1:0][DATA_W-1:0] test_loop_r;
	logic [CH_COUNT-1:0][DATA_W-1:0] test_loop_nxt;
	logic [DATA_W-1:0] rd_data_nxt;

	// Decoded values before the output flops
	logic [CH_COUNT-1:0][1:0] bw_dec;
	logic [CH_COUNT-1:0][6:0] depth_dec;
	logic [CH_COUNT-1:0][5:0] delay_dec;
	logic [CH_COUNT-1:0][1:0] pat_dec;
	logic [CH_COUNT-1:0] inv_dec;
	logic [CH_COUNT-1:0] pwr_dec;
	logic [CH_COUNT-1:0][2:0] loop_dec;

	logic [CH_IDX_W-1:0] ch_idx;
	logic sel_jitter;
	logic sel_test_loop;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	lcdr_addr_dec #(
		.CH_COUNT(CH_COUNT)
	) u_addr_dec (
		.addr_i(addr_i),
		.ch_idx_o(ch_idx),
		.sel_jitter_o(sel_jitter),
		.sel_test_loop_o(sel_test_loop)
	);

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_comb begin
		jitter_cfg_nxt = jitter_cfg_r;
		test_loop_nxt = test_loop_r;
		if (wr_en_i && sel_jitter) begin
			// Upper bits of this address belong to other blocks
			jitter_cfg_nxt[ch_idx] = wr_data_i[1:0];
		end
		if (wr_en_i && sel_test_loop) begin
			test_loop_nxt[ch_idx] = wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < CH_COUNT; i++) begin
				jitter_cfg_r[i] <= JITTER_CFG_RST[1:0];
				test_loop_r[i] <= TEST_LOOP_RST;
			end
		end else begin
			jitter_cfg_r <= jitter_cfg_nxt;
			test_loop_r <= test_loop_nxt;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Data stand only in the cycle after the strobe; zero otherwise
	always_comb begin
		rd_data_nxt = READ_IDLE_VAL;
		if (rd_en_i && sel_jitter) begin
			rd_data_nxt = {6'h00, jitter_cfg_r[ch_idx]};
		end else if (rd_en_i && sel_test_loop) begin
			rd_data_nxt = test_loop_r[ch_idx];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_data_o <= READ_IDLE_VAL;
		end else begin
			rd_data_o <= rd_data_nxt;
		end
	end

	// ------------------------------------------------------------
	// Per-channel decode
	// ------------------------------------------------------------
	for (genvar c = 0; c < CH_COUNT; c++) begin : g_ch
		lcdr_ch_decode u_dec (
			.jitter_cfg_i({6'h00, jitter_cfg_r[c]}),
			.test_loop_i(test_loop_r[c]),
			.e1_mode_i(e1_mode_i[c]),
			.global_tx_enable_i(global_tx_enable_i),
			.ja_bandwidth_o(bw_dec[c]),
			.ja_fifo_depth_o(depth_dec[c]),
			.ja_fifo_delay_o(delay_dec[c]),
			.tx_pattern_o(pat_dec[c]),
			.tx_pattern_invert_o(inv_dec[c]),
			.tx_power_on_o(pwr_dec[c]),
			.loopback_o(loop_dec[c])
		);
	end

	// ------------------------------------------------------------
	// Output flops
	// ------------------------------------------------------------
	// One bandwidth and one depth per channel feed both attenuator paths,
	// so receive and transmit can never disagree.
	// Costs one cycle of latency from a write to the outputs.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < CH_COUNT; i++) begin
				ja_bandwidth_o[i] <= LCDR_BW_10HZ;
				ja_fifo_depth_o[i] <= FIFO_DEPTH_SHORT;
				ja_fifo_delay_o[i] <= FIFO_DEPTH_SHORT[6:1];
				tx_pattern_o[i] <= LCDR_PAT_NONE;
				loopback_o[i] <= LCDR_LOOP_NONE;
			end
			tx_pattern_invert_o <= '0;
			tx_power_on_o <= '0;
		end else begin
			ja_bandwidth_o <= bw_dec;
			ja_fifo_depth_o <= depth_dec;
			ja_fifo_delay_o <= delay_dec;
			tx_pattern_o <= pat_dec;
			tx_pattern_invert_o <= inv_dec;
			tx_power_on_o <= pwr_dec;
			loopback_o <= loop_dec;
		end
	end

endmodule

// *** verification/lcdr_ctrl_regs_monitor.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Channel 0 watch; the power-off check covers every channel
// ------------------------------------------------------------
module lcdr_ctrl_regs_monitor #(
	parameter int CH_COUNT = 14
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [lcdr_pkg::ADDR_W-1:0] addr_i,
	input wire logic [lcdr_pkg::DATA_W-1:0] wr_data_i,
	input wire logic wr_en_i,
	input wire logic [CH_COUNT-1:0] e1_mode_i,
	input wire logic global_tx_enable_i,
	input wire logic [CH_COUNT-1:0][1:0] ja_bandwidth_o,
	input wire logic [CH_COUNT-1:0][6:0] ja_fifo_depth_o,
	input wire logic [CH_COUNT-1:0][5:0] ja_fifo_delay_o,
	input wire logic [CH_COUNT-1:0] tx_power_on_o,
	input wire logic [CH_COUNT-1:0][2:0] loopback_o
);
	import lcdr_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// Second cycle must be quiet, or a rewrite would mask the first
	sequence s_wr_bw;
		wr_en_i && addr_i == 8'h01 && wr_data_i[1] ##1 e1_mode_i[0] && !wr_en_i;
	endsequence
	sequence s_wr_on;
		wr_en_i && addr_i == 8'h02 && wr_data_i[3] ##1 global_tx_enable_i && !wr_en_i;
	endsequence
	sequence s_wr_noloop;
		wr_en_i && addr_i == 8'h02 && !wr_data_i[2] ##1 !wr_en_i;
	endsequence
	sequence s_wr_depth;
		wr_en_i && addr_i == 8'h01 ##1 !wr_en_i;
	endsequence
	sequence s_wr_digital;
		wr_en_i && addr_i == 8'h02 && wr_data_i[2:0] == 3'h7 ##1 !wr_en_i;
	endsequence
	property p_bw_t1; !e1_mode_i[0] |=> ja_bandwidth_o[0] == 2'h2; endproperty
	property p_bw_e1; s_wr_bw |=> ja_bandwidth_o[0] == 2'h1; endproperty
	// Depth must follow the written select bit, not merely be legal
	property p_depth;
		s_wr_depth |=> ja_fifo_depth_o[0] == ($past(wr_data_i[0], 2) ? 7'h40 : 7'h20);
	endproperty
	property p_delay; ja_fifo_delay_o[0] == ja_fifo_depth_o[0][6:1]; endproperty
	property p_pwr_off; !global_tx_enable_i |=> tx_power_on_o == '0; endproperty
	property p_pwr_on; s_wr_on |=> tx_power_on_o[0]; endproperty
	property p_loop_off; s_wr_noloop |=> loopback_o[0] == 3'h0; endproperty
	property p_loop_code; s_wr_digital |=> loopback_o[0] == 3'h4; endproperty
	a_bw_t1: assert property (p_bw_t1)
		else $error("T1 bandwidth not 3Hz");
	a_bw_e1: assert property (p_bw_e1)
		else $error("E1 bandwidth not 1.5Hz");
	a_depth: assert property (p_depth)
		else $error("fifo depth does not follow select bit");
	a_delay: assert property (p_delay)
		else $error("fifo delay not half depth");
	a_pwr_off: assert property (p_pwr_off)
		else $error("transmitter on with global pin low");
	a_pwr_on: assert property (p_pwr_on)
		else $error("transmitter not powered");
	a_loop_off: assert property (p_loop_off)
		else $error("loopback active for 0XX");
	a_loop_code: assert property (p_loop_code)
		else $error("digital loopback not reported");
endmodule
bind lcdr_ctrl_regs lcdr_ctrl_regs_monitor #(.CH_COUNT(CH_COUNT)) u_mon (.clk_i, .rst_n_i,
	.addr_i, .wr_data_i, .wr_en_i, .e1_mode_i, .global_tx_enable_i, .ja_bandwidth_o,
	.ja_fifo_depth_o, .ja_fifo_delay_o, .tx_power_on_o, .loopback_o);

// *** verification/test_lcdr_ctrl_regs.sv ***
`timescale 1ns/1ns
module test_lcdr_ctrl_regs;
	import lcdr_pkg::*;
	logic clk_i = 1'b0, rst_n_i = 1'b0, wr_en_i = 1'b0, rd_en_i = 1'b0, global_tx_enable_i = 1'b0;
	logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, jr[16], tr[16];
	logic [13:0] e1_mode_i = 14'h0000, power, inv;
	logic [13:0][1:0] bw, pat;
	logic [13:0][6:0] depth;
	logic [13:0][5:0] dly;
	logic [13:0][2:0] loopb;
	int miscompares = 0, compares = 0;
	always #4 clk_i = ~clk_i;
	lcdr_ctrl_regs #(.CH_COUNT(14)) uut (.clk_i, .rst_n_i, .addr_i, .wr_data_i, .wr_en_i,
		.rd_en_i, .rd_data_o, .e1_mode_i, .global_tx_enable_i, .ja_bandwidth_o(bw),
		.ja_fifo_depth_o(depth), .ja_fifo_delay_o(dly), .tx_pattern_o(pat),
		.tx_pattern_invert_o(inv), .tx_power_on_o(power), .loopback_o(loopb));
	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [7:0] x_pat(logic [7:0] t);
		return t[6] ? (t[5:4] == 2'h0 ? 8'h01 : (t[5:4] == 2'h1 ? 8'h02 : 8'h03)) : 8'h00;
	endfunction
	task automatic chk_all();
		logic [7:0] p;
		for (int c = 0; c < 14; c++) begin
			p = x_pat(tr[c]);
			chk("bw", e1_mode_i[c] ? {7'h00, jr[c][1]} : 8'h02, {6'h00, bw[c]});
			chk("depth", jr[c][0] ? 8'h40 : 8'h20, {1'b0, depth[c]});
			chk("delay", jr[c][0] ? 8'h20 : 8'h10, {2'h0, dly[c]});
			chk("pattern", p, {6'h00, pat[c]});
			chk("invert", {7'h00, tr[c][7] ^ (p == 8'h01)}, {7'h00, inv[c]});
			chk("power", {7'h00, global_tx_enable_i & tr[c][3]}, {7'h00, power[c]});
			chk("loop", tr[c][2] ? tr[c][1:0] + 8'h01 : 8'h00, {5'h00, loopb[c]});
		end
	endtask
	// ------------------------------------------------------------
	// Stimulus: write, check decode, read back
	// ------------------------------------------------------------
	task automatic step(logic [7:0] a, logic [7:0] d);
		logic m;
		m = a[7:4] < 4'he;
		@(posedge clk_i);
		e1_mode_i <= 14'($urandom);
		global_tx_enable_i <= ($urandom % 4) != 0;
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_i);
		// Read strobe right behind the write: must already see the new value
		wr_en_i <= 1'b0;
		rd_en_i <= 1'b1;
		if (m && a[3:0] == 4'h1) jr[a[7:4]] = {6'h00, d[1:0]};
		if (m && a[3:0] == 4'h2) tr[a[7:4]] = d;
		@(posedge clk_i);
		rd_en_i <= 1'b0;
		#1 chk_all();
		chk("rdback", a[3:0] == 4'h1 ? jr[a[7:4]] : (a[3:0] == 4'h2 ? tr[a[7:4]] : 8'h00),
			rd_data_o);
		// Read data stand one cycle only
		@(posedge clk_i);
		#1 chk("rdidle", 8'h00, rd_data_o);
	endtask
	task automatic do_reset();
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (jr[i]) begin
			jr[i] = 8'h00;
			tr[i] = 8'h00;
		end
		@(posedge clk_i);
		#1 chk_all();
	endtask
	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hb063e176));
		do_reset();
		for (int i = 0; i < 8; i++) step(8'h02, {i[0], i[2:0], 1'b1, i[2:0]});
		step(8'hd1, 8'hff);
		step(8'h01, 8'h03);
		step(8'he2, 8'hff);
		step(8'h03, 8'hff);
		for (int i = 0; i < 300; i++) step({4'($urandom), 4'($urandom % 4)}, 8'($urandom));
		do_reset();
		for (int i = 0; i < 100; i++) step({4'($urandom), 4'($urandom % 4)}, 8'($urandom));
		give_verdict();
	end
	initial begin
		#80000;
		miscompares++;
		give_verdict();
	end
endmodule
